// ### design/pprl_pkg.sv
// Package for the printer port register logic: register indices, bit
// positions, reset values, timing constants and the state record.
// Assumes a single 25 MHz clock and an Avalon-MM word-addressed slave.
`default_nettype none

package pprl_pkg;

  // ----------------------------------------------------------------
  // Register indices (word addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [2:0] PPRL_IDX_DATA = 3'h0;
  localparam logic [2:0] PPRL_IDX_STATUS = 3'h1;
  localparam logic [2:0] PPRL_IDX_CONTROL = 3'h2;
  localparam logic [2:0] PPRL_IDX_MODE = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PPRL_CTL_STROBE = 0;
  localparam int PPRL_CTL_FEED = 1;
  localparam int PPRL_CTL_INIT = 2;
  localparam int PPRL_CTL_SELIN = 3;
  localparam int PPRL_CTL_IRQEN = 4;
  localparam int PPRL_CTL_DIR = 5;
  localparam int PPRL_MODE_ENH = 0;
  localparam int PPRL_MODE_ECP = 2;
  localparam int PPRL_MODE_LINESEL = 3;
  localparam int PPRL_MODE_IRQSTAT = 4;
  localparam int PPRL_MODE_EXT = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PPRL_MCLK_NS = 40;
  localparam int PPRL_TIMEOUT_NS = 10000;
  // Least time, so round up
  localparam int PPRL_TIMEOUT_CYCLES = (PPRL_TIMEOUT_NS + PPRL_MCLK_NS - 1) / PPRL_MCLK_NS;
  localparam logic [7:0] PPRL_TIMEOUT_LAST = 8'(PPRL_TIMEOUT_CYCLES - 1);
  localparam logic [7:0] PPRL_TIMEOUT_DONE = 8'(PPRL_TIMEOUT_CYCLES);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dataLatch;
    logic strobeBit;
    logic feedBit;
    logic initBit;
    logic selInBit;
    logic ackIrqEnable;
    logic directionBit;
    logic enhEnable;
    logic ecpEnable;
    logic irqStatusCfg;
    logic irqLineSelect;
    logic modeExtension;
    logic pinDrive;
    logic timeoutFlag;
    logic irqStatus;
    logic [7:0] timeoutCount;
    logic ackPrev;
    logic waitReq;
    logic [7:0] readByte;
    logic [7:0] dataOut;
    logic dataOe;
    logic strobeN;
    logic feedN;
    logic selInN;
    logic initN;
    logic [1:0] irqLines;
    logic [1:0] irqOe;
  } pprl_state_t;

  localparam pprl_state_t PPRL_STATE_RESET = '{
    dataLatch: 8'h00, strobeBit: 1'b0, feedBit: 1'b0, initBit: 1'b0, selInBit: 1'b0,
    ackIrqEnable: 1'b0, directionBit: 1'b0, enhEnable: 1'b0, ecpEnable: 1'b0,
    irqStatusCfg: 1'b0, irqLineSelect: 1'b0, modeExtension: 1'b0, pinDrive: 1'b0,
    timeoutFlag: 1'b0, irqStatus: 1'b1, timeoutCount: 8'h00, ackPrev: 1'b1,
    waitReq: 1'b1, readByte: 8'h00, dataOut: 8'h00, dataOe: 1'b1, strobeN: 1'b1,
    feedN: 1'b1, selInN: 1'b1, initN: 1'b0, irqLines: 2'h0, irqOe: 2'h0};

endpackage : pprl_pkg

`default_nettype wire

// ### design/pprl_sync.sv
// Two-stage synchroniser for a bundle of cable inputs.
// Assumes each bit is an independent level; no word coherence is given.
`default_nettype none

module pprl_sync #(
  parameter int WIDTH = 13
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] firstStage;
    logic [WIDTH-1:0] secondStage;
  } pprl_sync_state_t;

  pprl_sync_state_t s;
  pprl_sync_state_t next_s;

  always_comb begin
    next_s.firstStage = asyncIn;
    next_s.secondStage = s.firstStage;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign syncOut = s.secondStage;

endmodule : pprl_sync

`default_nettype wire

// ### design/pprl_top.sv
// Printer port register logic: data, status and control registers plus a
// mode register, reached over Avalon-MM, driving a parallel printer cable.
// Assumes cable inputs are asynchronous and eppCycleBusy comes from mclk logic.
//
// What this block does
// - Compatible mode: a data write drives the byte onto the cable lines.
// - Compatible mode: data reads return the output latch, not the lines.
// - Extended mode, direction 0: latch drives lines, reads return the latch.
// - Extended mode, direction 1: writes only latch, reads return sampled lines.
// - Reset clears the data latch to zero.
// - Status is read-only; writing it changes nothing.
// - Enhanced mode: status bit 0 sets after a transfer stalls 10 us.
// - Reading status clears the timeout bit.
// - Turning enhanced mode on clears the timeout bit.
// - Outside enhanced mode the timeout bit reads 1.
// - Status bit 1 always reads 1.
// - Status bit 2 reads 1 in compatible mode without enhanced/ECP, or in enhanced/ECP mode with interrupt-status off.
// - Extended mode with ack interrupt on: ack rising latches bit 2 low.
// - Reading status sets the latched interrupt status back to 1.
// - Status bits 3..6 show error, select, paper-out, ack directly.
// - Status bit 7 is the inverse of the busy line.
// - Control bits 0, 1, 3 drive strobe, feed, select-in inverted.
// - Control bit 2 drives printer-initialise with same polarity.
// - Interrupt floats when bit 4 is 0, else behaves per mode.
// - Control bit 5 is direction; reads back only in enhanced mode, else 1.
// - Control bits 6 and 7 always read 1.
`default_nettype none

module pprl_top
  import pprl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] cableDataIn,
  output logic [7:0] cableDataOut,
  output logic cableDataOe,
  output logic cableStrobeN,
  output logic cableStrobeOe,
  output logic autoLineFeedN,
  output logic autoLineFeedOe,
  output logic selectInOutN,
  output logic selectInOutOe,
  output logic printerInitN,
  input wire logic ackN,
  input wire logic busyIn,
  input wire logic paperOutIn,
  input wire logic printerSelectedIn,
  input wire logic errorN,
  input wire logic eppCycleBusy,
  output logic [1:0] portInterruptLines,
  output logic [1:0] portInterruptOe
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hitsReg(input logic [2:0] addr, input logic [2:0] idx);
    hitsReg = (addr == idx);
  endfunction : hitsReg

  pprl_state_t s;
  pprl_state_t next_s;

  logic [12:0] syncBits;
  logic [7:0] dataSync;
  logic ackSync;
  logic busySync;
  logic paperSync;
  logic selectSync;
  logic errorSync;

  // ----------------------------------------------------------------
  // Cable input synchronisers
  // ----------------------------------------------------------------
  pprl_sync #(
    .WIDTH(13)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn({cableDataIn, ~ackN, busyIn, paperOutIn, printerSelectedIn, errorN}),
    .syncOut(syncBits)
  );

  assign dataSync = syncBits[12:5];
  // Ack enters inverted so a cleared synchroniser reads idle-high: no false edge after reset
  assign ackSync = ~syncBits[4];
  assign busySync = syncBits[3];
  assign paperSync = syncBits[2];
  assign selectSync = syncBits[1];
  assign errorSync = syncBits[0];

  logic busReq;
  logic busCommit;
  logic wrCommit;
  logic statusRead;
  logic ackRise;
  logic ackFall;
  logic timeoutHit;
  logic reverseMode;
  logic showIrqStatus;
  logic wrLow;
  logic [7:0] statusByte;
  logic [7:0] controlByte;
  logic [7:0] modeByte;
  logic [7:0] readMux;

  assign busReq = avs_read | avs_write;
  // Request commits at the edge where waitrequest is seen low
  assign busCommit = busReq & ~s.waitReq;
  assign wrCommit = busCommit & avs_write;
  assign wrLow = wrCommit & avs_byteenable[0];
  assign statusRead = busCommit & avs_read & hitsReg(avs_address, PPRL_IDX_STATUS);
  assign ackRise = ackSync & ~s.ackPrev;
  assign ackFall = ~ackSync & s.ackPrev;
  assign reverseMode = s.modeExtension & s.directionBit;
  assign timeoutHit = s.enhEnable & eppCycleBusy & (s.timeoutCount == PPRL_TIMEOUT_LAST);
  // Enhanced/capability modes take the config bit, otherwise extension decides
  assign showIrqStatus = (s.enhEnable | s.ecpEnable) ? s.irqStatusCfg : s.modeExtension;

  // ----------------------------------------------------------------
  // Read values
  // ----------------------------------------------------------------
  always_comb begin
    // timeout bit reads 1 outside enhanced mode
    statusByte[0] = s.enhEnable ? s.timeoutFlag : 1'b1;
    statusByte[1] = 1'b1;
    // fixed 1 unless interrupt status is shown
    statusByte[2] = showIrqStatus ? s.irqStatus : 1'b1;
    statusByte[3] = errorSync;
    statusByte[4] = selectSync;
    statusByte[5] = paperSync;
    statusByte[6] = ackSync;
    statusByte[7] = ~busySync;
    // direction reads back only in enhanced mode
    controlByte = {2'b11, (s.enhEnable ? s.directionBit : 1'b1), s.ackIrqEnable,
                   s.selInBit, s.initBit, s.feedBit, s.strobeBit};
    modeByte = 8'h00;
    modeByte[PPRL_MODE_ENH] = s.enhEnable;
    modeByte[PPRL_MODE_ECP] = s.ecpEnable;
    modeByte[PPRL_MODE_LINESEL] = s.irqLineSelect;
    modeByte[PPRL_MODE_IRQSTAT] = s.irqStatusCfg;
    modeByte[PPRL_MODE_EXT] = s.modeExtension;
    case (avs_address)
      PPRL_IDX_DATA: readMux = reverseMode ? dataSync : s.dataLatch;
      PPRL_IDX_STATUS: readMux = statusByte;
      PPRL_IDX_CONTROL: readMux = controlByte;
      PPRL_IDX_MODE: readMux = modeByte;
      default: readMux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ackPrev = ackSync;
    // One wait cycle, then the answer; unmapped reads give zero
    next_s.waitReq = ~(busReq & s.waitReq);
    if (busReq & s.waitReq) begin
      next_s.readByte = avs_read ? readMux : 8'h00;
    end

    if (wrLow) begin
      case (avs_address)
        // a data write always lands in the latch
        PPRL_IDX_DATA: next_s.dataLatch = avs_writedata[7:0];
        PPRL_IDX_CONTROL: begin
          next_s.strobeBit = avs_writedata[PPRL_CTL_STROBE];
          next_s.feedBit = avs_writedata[PPRL_CTL_FEED];
          next_s.initBit = avs_writedata[PPRL_CTL_INIT];
          next_s.selInBit = avs_writedata[PPRL_CTL_SELIN];
          next_s.ackIrqEnable = avs_writedata[PPRL_CTL_IRQEN];
          next_s.directionBit = avs_writedata[PPRL_CTL_DIR];
          next_s.pinDrive = 1'b1;
        end
        PPRL_IDX_MODE: begin
          next_s.enhEnable = avs_writedata[PPRL_MODE_ENH];
          next_s.ecpEnable = avs_writedata[PPRL_MODE_ECP];
          next_s.irqLineSelect = avs_writedata[PPRL_MODE_LINESEL];
          next_s.irqStatusCfg = avs_writedata[PPRL_MODE_IRQSTAT];
          next_s.modeExtension = avs_writedata[PPRL_MODE_EXT];
          // enabling enhanced mode clears a stale timeout
          if (!s.enhEnable && avs_writedata[PPRL_MODE_ENH]) begin
            next_s.timeoutFlag = 1'b0;
          end
        end
        // status and unmapped writes fall through untouched
        default: begin
        end
      endcase
    end

    // status read clears the timeout bit
    if (statusRead) begin
      next_s.timeoutFlag = 1'b0;
      next_s.irqStatus = 1'b1;
    end

    // Saturating stall counter; restarts whenever the engine goes idle
    if (s.enhEnable & eppCycleBusy) begin
      if (s.timeoutCount != PPRL_TIMEOUT_DONE) begin
        next_s.timeoutCount = s.timeoutCount + 8'h01;
      end
    end else begin
      next_s.timeoutCount = 8'h00;
    end
    // event beats a clear in the same cycle
    if (timeoutHit) begin
      next_s.timeoutFlag = 1'b1;
    end
    // ack rising latches status low, winning over a read
    if (s.modeExtension & s.ackIrqEnable & ackRise) begin
      next_s.irqStatus = 1'b0;
    end

    // Pins follow the updated register values
    // compatible mode always drives
    next_s.dataOut = next_s.dataLatch;
    next_s.dataOe = ~(next_s.modeExtension & next_s.directionBit);
    // inverted drive of strobe, feed, select-in
    next_s.strobeN = ~next_s.strobeBit;
    next_s.feedN = ~next_s.feedBit;
    next_s.selInN = ~next_s.selInBit;
    // same polarity, so 0 initialises the printer
    next_s.initN = next_s.initBit;

    // floated when disabled, otherwise per mode
    next_s.irqLines = 2'h0;
    next_s.irqOe = 2'h0;
    if (next_s.ackIrqEnable) begin
      if (s.enhEnable) begin
        next_s.irqLines[next_s.irqLineSelect] = ackFall | timeoutHit;
      end else if (s.modeExtension) begin
        next_s.irqLines[next_s.irqLineSelect] = ~next_s.irqStatus;
      end else begin
        next_s.irqLines[next_s.irqLineSelect] = ackSync;
      end
      next_s.irqOe[next_s.irqLineSelect] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= PPRL_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Strobe, feed and select-in stay released until software sets control
  assign avs_readdata = {24'h000000, s.readByte};
  assign avs_waitrequest = s.waitReq;
  assign cableDataOut = s.dataOut;
  assign cableDataOe = s.dataOe;
  assign cableStrobeN = s.strobeN;
  assign cableStrobeOe = s.pinDrive;
  assign autoLineFeedN = s.feedN;
  assign autoLineFeedOe = s.pinDrive;
  assign selectInOutN = s.selInN;
  assign selectInOutOe = s.pinDrive;
  assign printerInitN = s.initN;
  assign portInterruptLines = s.irqLines;
  assign portInterruptOe = s.irqOe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_compat_drive: assert property (
    (wrLow && hitsReg(avs_address, PPRL_IDX_DATA) && !s.modeExtension)
    |=> (cableDataOe && cableDataOut == $past(avs_writedata[7:0])))
    else $error("compatible data write not driven to lines");

  a_latch_readback: assert property (
    (busReq && s.waitReq && avs_read && hitsReg(avs_address, PPRL_IDX_DATA) && !reverseMode)
    |=> (avs_readdata[7:0] == s.dataLatch && !avs_waitrequest))
    else $error("data read did not return latch");

  a_reverse_float: assert property (
    (reverseMode && !wrCommit) |=> !cableDataOe)
    else $error("lines driven in reverse direction");

  a_status_readonly: assert property (
    (wrCommit && hitsReg(avs_address, PPRL_IDX_STATUS))
    |=> ($stable(s.dataLatch) && $stable(controlByte) && $stable(modeByte)))
    else $error("status write changed state");

  a_timeout_set: assert property (
    timeoutHit |=> (s.timeoutFlag && statusByte[0]))
    else $error("timeout not flagged");

  a_timeout_clear: assert property (
    (statusRead && !timeoutHit) |=> !s.timeoutFlag)
    else $error("status read did not clear timeout");

  a_fixed_ones: assert property (
    !s.enhEnable |-> (statusByte[1:0] == 2'h3 && controlByte[7:5] == 3'h7))
    else $error("fixed status or control bits not one");

  a_irqstat_latch: assert property (
    (s.modeExtension && s.ackIrqEnable && ackRise) |=> (!s.irqStatus ##1 portInterruptOe != 2'h0))
    else $error("ack rise did not latch interrupt status");

  a_ctl_pins: assert property (
    (wrLow && hitsReg(avs_address, PPRL_IDX_CONTROL))
    |=> (cableStrobeN == !$past(avs_writedata[0]) && selectInOutN == !$past(avs_writedata[3])
         && printerInitN == $past(avs_writedata[2]) && cableStrobeOe))
    else $error("control pins do not follow written bits");

  a_irq_float: assert property (
    !s.ackIrqEnable |-> (portInterruptOe == 2'h0 && portInterruptLines == 2'h0))
    else $error("interrupt driven while disabled");

  a_bus_answer: assert property (
    (busReq && s.waitReq) |=> (!avs_waitrequest ##1 avs_waitrequest))
    else $error("bus answer not one cycle wait");

  c_timeout: cover property (timeoutHit ##[1:20] statusRead);
  c_reverse_read: cover property (reverseMode && busCommit && avs_read && hitsReg(avs_address, PPRL_IDX_DATA));
  c_ack_irq: cover property (s.modeExtension && s.ackIrqEnable && ackRise);
  c_epp_pulse: cover property (s.enhEnable && s.ackIrqEnable && ackFall);

endmodule : pprl_top

`default_nettype wire

// ### tb/pprl_printer_model.sv
// Behavioural printer on the cable side of the port register logic.
// Assumes the bench sets the peripheral data, its drive enable and the line flags.
`default_nettype none

module pprl_printer_model (
  input wire logic mclk,
  input wire logic [7:0] cableDataOut,
  input wire logic cableDataOe,
  input wire logic cableStrobeN,
  input wire logic [7:0] periphData,
  input wire logic periphDrive,
  input wire logic [2:0] lineFlags,
  input wire logic [3:0] ackDelay,
  output logic [7:0] cableDataIn,
  output logic ackN,
  output logic busyIn,
  output logic paperOutIn,
  output logic printerSelectedIn,
  output logic errorN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lastLevel = 8'h00;

  // Undriven lines toggle so a stale byte never passes for real data
  assign cableDataIn = cableDataOe ? cableDataOut : (periphDrive ? periphData : ~lastLevel);
  assign {paperOutIn, printerSelectedIn, errorN} = lineFlags;

  always @(posedge mclk) begin
    lastLevel <= cableDataIn;
  end

  // Busy on each strobe, then an acknowledge pulse after a chosen delay
  initial begin
    ackN = 1'b1;
    busyIn = 1'b0;
    forever begin
      @(negedge cableStrobeN);
      @(posedge mclk);
      busyIn <= 1'b1;
      repeat (ackDelay) @(posedge mclk);
      ackN <= 1'b0;
      repeat (4) @(posedge mclk);
      ackN <= 1'b1;
      busyIn <= 1'b0;
    end
  end
endmodule : pprl_printer_model

`default_nettype wire

// ### tb/pprl_top_tb_top.sv
// Self-checking bench for the printer port register logic.
// Assumes the design package and the printer model are compiled first.
`default_nettype none

module pprl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pprl_pkg::*;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic eppCycleBusy = 1'b0;
  logic [7:0] periphData = 8'hC3;
  logic periphDrive = 1'b0;
  logic [2:0] lineFlags = 3'b101;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] cableDataIn;
  logic [7:0] cableDataOut;
  logic cableDataOe, cableStrobeN, cableStrobeOe, autoLineFeedN, autoLineFeedOe;
  logic selectInOutN, selectInOutOe, printerInitN;
  logic ackN, busyIn, paperOutIn, printerSelectedIn, errorN;
  logic [1:0] portInterruptLines;
  logic [1:0] portInterruptOe;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  logic [7:0] rd;

  always #20 mclk = ~mclk;

  pprl_top dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cableDataIn(cableDataIn),
    .cableDataOut(cableDataOut), .cableDataOe(cableDataOe), .cableStrobeN(cableStrobeN),
    .cableStrobeOe(cableStrobeOe), .autoLineFeedN(autoLineFeedN), .autoLineFeedOe(autoLineFeedOe),
    .selectInOutN(selectInOutN), .selectInOutOe(selectInOutOe), .printerInitN(printerInitN),
    .ackN(ackN), .busyIn(busyIn), .paperOutIn(paperOutIn), .printerSelectedIn(printerSelectedIn),
    .errorN(errorN), .eppCycleBusy(eppCycleBusy), .portInterruptLines(portInterruptLines),
    .portInterruptOe(portInterruptOe));

  pprl_printer_model printer (.mclk(mclk), .cableDataOut(cableDataOut), .cableDataOe(cableDataOe),
    .cableStrobeN(cableStrobeN), .periphData(periphData), .periphDrive(periphDrive),
    .lineFlags(lineFlags), .ackDelay(4'h3), .cableDataIn(cableDataIn), .ackN(ackN),
    .busyIn(busyIn), .paperOutIn(paperOutIn), .printerSelectedIn(printerSelectedIn), .errorN(errorN));

  // ----------------------------------------------------------------
  // Bus master and checking
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : bus_rd

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      nErrors++;
    end
  endtask : chk

  // Idle printer: not busy, ack high, flags as set by the bench
  function automatic logic [7:0] expStatus(input logic irq, input logic tmo);
    return {1'b1, 1'b1, lineFlags[2], lineFlags[1], lineFlags[0], irq, 1'b1, tmo};
  endfunction : expStatus

  task automatic stop_test();
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    bus_rd(PPRL_IDX_DATA, rd);
    chk("data", 8'h00, rd);
    bus_rd(PPRL_IDX_CONTROL, rd);
    chk("control", 8'hE0, rd);
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("status", expStatus(1'b1, 1'b1), rd);
    chk("pins", 8'h01, {3'h0, printerInitN, cableStrobeOe, autoLineFeedOe, selectInOutOe, ~|portInterruptOe});
  endtask : t_reset

  task automatic t_data_paths();
    bus_wr(PPRL_IDX_DATA, 8'hA5);
    chk("out", 8'hA5, cableDataOut);
    bus_rd(PPRL_IDX_DATA, rd);
    chk("latch", 8'hA5, rd);
    bus_wr(PPRL_IDX_MODE, 8'h80);
    periphDrive <= 1'b1;
    bus_wr(PPRL_IDX_CONTROL, 8'h20);
    chk("oe", 8'h00, 8'(cableDataOe));
    bus_wr(PPRL_IDX_DATA, 8'h5A);
    bus_rd(PPRL_IDX_DATA, rd);
    chk("lines", 8'hC3, rd);
    periphDrive <= 1'b0;
    bus_wr(PPRL_IDX_CONTROL, 8'h00);
    chk("out", 8'h5A, cableDataOe ? cableDataOut : 8'h00);
    bus_rd(PPRL_IDX_DATA, rd);
    chk("latch", 8'h5A, rd);
    bus_wr(PPRL_IDX_MODE, 8'h00);
    bus_wr(PPRL_IDX_STATUS, 8'hFF);
    bus_rd(PPRL_IDX_DATA, rd);
    chk("data", 8'h5A, rd);
    bus_rd(PPRL_IDX_CONTROL, rd);
    chk("control", 8'hE0, rd);
  endtask : t_data_paths

  task automatic t_ctrl_pins();
    bus_wr(PPRL_IDX_CONTROL, 8'h0B);
    chk("pinsN", 8'h00, {4'h0, cableStrobeN, autoLineFeedN, selectInOutN, printerInitN});
    chk("pinsOe", 8'h07, {5'h0, cableStrobeOe, autoLineFeedOe, selectInOutOe});
    bus_rd(PPRL_IDX_CONTROL, rd);
    chk("control", 8'hEB, rd);
    bus_wr(PPRL_IDX_CONTROL, 8'h04);
    chk("pinsN", 8'h0F, {4'h0, cableStrobeN, autoLineFeedN, selectInOutN, printerInitN});
    repeat (20) @(posedge mclk);
  endtask : t_ctrl_pins

  task automatic t_ack_irq();
    bus_wr(PPRL_IDX_MODE, 8'h80);
    bus_wr(PPRL_IDX_CONTROL, 8'h15);
    bus_wr(PPRL_IDX_CONTROL, 8'h14);
    repeat (20) @(posedge mclk);
    chk("irq", 8'h05, {4'h0, portInterruptOe, portInterruptLines});
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("status", expStatus(1'b0, 1'b1), rd);
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("status", expStatus(1'b1, 1'b1), rd);
    chk("irq", 8'h04, {4'h0, portInterruptOe, portInterruptLines});
    bus_wr(PPRL_IDX_MODE, 8'h00);
    bus_wr(PPRL_IDX_CONTROL, 8'h14);
    chk("irq", 8'h05, {4'h0, portInterruptOe, portInterruptLines});
    // Strobe makes the printer pulse ack; sample inside the low window
    bus_wr(PPRL_IDX_CONTROL, 8'h15);
    repeat (8) @(posedge mclk);
    chk("irq", 8'h04, {4'h0, portInterruptOe, portInterruptLines});
    bus_wr(PPRL_IDX_CONTROL, 8'h04);
  endtask : t_ack_irq

  task automatic t_timeout();
    bus_wr(PPRL_IDX_MODE, 8'h01);
    bus_rd(PPRL_IDX_CONTROL, rd);
    chk("control", 8'hC4, rd);
    eppCycleBusy <= 1'b1;
    repeat (200) @(posedge mclk);
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("early", expStatus(1'b1, 1'b0), rd);
    repeat (60) @(posedge mclk);
    eppCycleBusy <= 1'b0;
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("timeout", expStatus(1'b1, 1'b1), rd);
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("cleared", expStatus(1'b1, 1'b0), rd);
    eppCycleBusy <= 1'b1;
    repeat (260) @(posedge mclk);
    eppCycleBusy <= 1'b0;
    // Flag left set: re-enabling must clear it without any status read
    bus_wr(PPRL_IDX_MODE, 8'h00);
    bus_wr(PPRL_IDX_MODE, 8'h01);
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("enable", expStatus(1'b1, 1'b0), rd);
    bus_wr(PPRL_IDX_MODE, 8'h00);
    bus_rd(PPRL_IDX_STATUS, rd);
    chk("compat", expStatus(1'b1, 1'b1), rd);
  endtask : t_timeout

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_data_paths();
    t_ctrl_pins();
    t_ack_irq();
    // initialise bit stays set before enhanced mode is enabled
    t_timeout();
    stop_test();
  end
endmodule : pprl_top_tb_top

`default_nettype wire
